//--- hdl/brf_banked_register_file.sv
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module brf_banked_register_file
  import brf_pkg::*;
#(
  parameter int XLEN = 32
)
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] mode_i,
  input wire logic compact_i,
  input wire logic [3:0] rd_a_idx_i,
  input wire logic [3:0] rd_b_idx_i,
  input wire logic rd_high_form_i,
  input wire brf_wr_t wr_i,
  input wire logic branch_with_link_i,
  input wire logic [XLEN-1:0] link_value_i,
  input wire logic exc_entry_i,
  input wire logic [4:0] exc_mode_i,
  input wire logic [XLEN-1:0] exc_return_i,
  input wire logic ip_load_i,
  input wire logic [XLEN-1:0] ip_value_i,
  input wire logic csw_wr_i,
  input wire logic [XLEN-1:0] csw_data_i,
  input wire logic ssw_wr_i,
  input wire logic [XLEN-1:0] ssw_data_i,
  output logic [XLEN-1:0] rd_a_data_o,
  output logic [XLEN-1:0] rd_b_data_o,
  output logic rd_a_denied_o,
  output logic rd_b_denied_o,
  output logic [XLEN-1:0] instruction_pointer_o,
  output logic [XLEN-1:0] current_status_word_o,
  output logic [XLEN-1:0] saved_status_word_o,
  output logic saved_valid_o
);

  // read results live in the state so data outputs come from flip-flops
  // all physical storage, 40 words and two deny bits in total
  typedef struct packed {
    logic [7:0][XLEN-1:0] low;       // r0-r7, shared everywhere
    logic [4:0][XLEN-1:0] usr_hi;    // r8-r12 user/system copies
    logic [4:0][XLEN-1:0] fiq_hi;    // r8-r12 fast interrupt copies
    logic [5:0][XLEN-1:0] sp_bank;   // r13 per bank
    logic [5:0][XLEN-1:0] link_bank; // r14 per bank
    logic [5:0][XLEN-1:0] ssw_bank;  // saved status per bank, usr slot unused
    logic [XLEN-1:0] ip;             // r15
    logic [XLEN-1:0] csw;            // current status word
    logic [XLEN-1:0] rd_a;           // registered read data
    logic [XLEN-1:0] rd_b;
    logic den_a;
    logic den_b;
  } brf_state_t;

  // registered state and its next value
  brf_state_t state_reg;
  brf_state_t state_next;

  // mode code to bank; system and unknown codes fall to user
  // an illegal code can never open a privileged bank
  function automatic brf_bank_t brf_bank_of(input logic [4:0] m);
    brf_bank_t b;
    b = BRF_BANK_USR;
    if (m == `BRF_MODE_FIQ) b = BRF_BANK_FIQ;
    else if (m == `BRF_MODE_IRQ) b = BRF_BANK_IRQ;
    else if (m == `BRF_MODE_SVC) b = BRF_BANK_SVC;
    else if (m == `BRF_MODE_ABT) b = BRF_BANK_ABT;
    else if (m == `BRF_MODE_UND) b = BRF_BANK_UND;
    else b = BRF_BANK_USR; // user and system share
    return b;
  endfunction

  // read one logical register through the current bank
  function automatic logic [XLEN-1:0] brf_read(input brf_state_t s, input brf_bank_t b,
                                               input logic [3:0] idx, input logic cmp);
    logic [XLEN-1:0] v;
    v = `BRF_ZERO_WORD;
    if (idx <= `BRF_REG_LOW_LAST) v = s.low[idx[2:0]];
    else if (idx < `BRF_REG_SP)
    begin
      // r8-r12: fast interrupt has its own five copies
      if (b == BRF_BANK_FIQ) v = s.fiq_hi[3'(idx - `BRF_REG_FIQ_FIRST)];
      else v = s.usr_hi[3'(idx - `BRF_REG_FIQ_FIRST)];
    end
    else if (idx == `BRF_REG_SP) v = s.sp_bank[b];
    else if (idx == `BRF_REG_LINK) v = s.link_bank[b];
    else
    begin
      // low pointer bits read as zero, consumers ignore them
      if (cmp) v = s.ip & `BRF_IP_MASK_COMPACT;
      else v = s.ip & `BRF_IP_MASK_WIDE;
    end
    return v;
  endfunction

  // compact state hides r8-r12 unless the special high form is used
  // r13-r15 stay reachable as stack, link and pointer in both states
  function automatic logic brf_hidden(input logic [3:0] idx, input logic cmp, input logic high_form);
    logic h;
    h = 1'b0;
    if (cmp && !high_form)
    begin
      // only the middle high registers are fenced off
      h = (idx > `BRF_REG_LOW_LAST) && (idx < `BRF_REG_SP);
    end
    return h;
  endfunction

  // bank of the live mode and of the exception target
  brf_bank_t cur_bank; // selects r13, r14 and saved word copies
  brf_bank_t exc_bank; // bank that an exception entry fills
  logic cmp_state; // high in compact state

  // bank and state decode from live inputs
  // the core holds mode and state stable for the whole cycle
  always_comb
  begin
    cur_bank = brf_bank_of(mode_i);
    exc_bank = brf_bank_of(exc_mode_i);
    cmp_state = compact_i;
  end

  // next-state logic for the whole file
  always_comb
  begin
    // default: hold every copy, so idle cycles change nothing
    state_next = state_reg;
    // reads; compact state hides high regs except special forms
    state_next.den_a = brf_hidden(rd_a_idx_i, cmp_state, rd_high_form_i);
    state_next.den_b = brf_hidden(rd_b_idx_i, cmp_state, rd_high_form_i);
    // reads see the old state; a same-cycle write is not forwarded
    // leaving forwarding out keeps the read path short, the core allows for it
    state_next.rd_a = state_next.den_a ? `BRF_ZERO_WORD : brf_read(state_reg, cur_bank, rd_a_idx_i, cmp_state);
    state_next.rd_b = state_next.den_b ? `BRF_ZERO_WORD : brf_read(state_reg, cur_bank, rd_b_idx_i, cmp_state);
    // pointer advance from the datapath; a general write to r15 below wins
    if (ip_load_i) state_next.ip = ip_value_i;
    // general write, only the selected physical copy
    // a refused compact write is dropped silently; a refused read returns zero and sets its deny bit
    if (wr_i.en && !brf_hidden(wr_i.idx, cmp_state, rd_high_form_i))
    begin
      // low registers are one copy for every mode and state
      if (wr_i.idx <= `BRF_REG_LOW_LAST) state_next.low[wr_i.idx[2:0]] = wr_i.data;
      else if (wr_i.idx < `BRF_REG_SP)
      begin
        // user and system share the usr_hi copies
        if (cur_bank == BRF_BANK_FIQ) state_next.fiq_hi[3'(wr_i.idx - `BRF_REG_FIQ_FIRST)] = wr_i.data;
        else state_next.usr_hi[3'(wr_i.idx - `BRF_REG_FIQ_FIRST)] = wr_i.data;
      end
      else if (wr_i.idx == `BRF_REG_SP) state_next.sp_bank[cur_bank] = wr_i.data;
      else if (wr_i.idx == `BRF_REG_LINK) state_next.link_bank[cur_bank] = wr_i.data;
      else state_next.ip = wr_i.data; // r15 as a plain register
    end
    // link write wins over a general write to r14 in the same cycle
    if (branch_with_link_i) state_next.link_bank[cur_bank] = link_value_i;
    // current status word, one copy for both states
    if (csw_wr_i) state_next.csw = csw_data_i;
    // saved word write; user and system have no saved word to write
    if (ssw_wr_i && cur_bank != BRF_BANK_USR) state_next.ssw_bank[cur_bank] = ssw_data_i;
    // exception entry last: it wins over link and general writes on r14
    // entry does not switch the mode; the core writes the status word itself
    if (exc_entry_i)
    begin
      // a user or system target has no saved word to fill
      state_next.link_bank[exc_bank] = exc_return_i;
      if (exc_bank != BRF_BANK_USR) state_next.ssw_bank[exc_bank] = state_reg.csw;
    end
  end

  // single state register
  // asynchronous reset so the file is defined before the first clock
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // clear every copy; status and pointer take their own reset values
      state_reg <= '0;
      state_reg.csw <= `BRF_SW_RESET;
      state_reg.ip <= `BRF_IP_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs; saved word invisible in user and system modes
  // pointer mask follows the live state flag, so a switch shows at once
  // saved word is muxed from the live mode with no extra cycle
  always_comb
  begin
    rd_a_data_o = state_reg.rd_a;
    rd_b_data_o = state_reg.rd_b;
    rd_a_denied_o = state_reg.den_a;
    rd_b_denied_o = state_reg.den_b;
    instruction_pointer_o = state_reg.ip & (cmp_state ? `BRF_IP_MASK_COMPACT : `BRF_IP_MASK_WIDE);
    current_status_word_o = state_reg.csw;
    saved_valid_o = (cur_bank != BRF_BANK_USR);
    saved_status_word_o = saved_valid_o ? state_reg.ssw_bank[cur_bank] : `BRF_ZERO_WORD;
  end

endmodule
`default_nettype wire

//--- hdl/brf_cfg.svh
`ifndef BRF_CFG_SVH
`define BRF_CFG_SVH
// mode field codes
`define BRF_MODE_USR 5'h10
`define BRF_MODE_FIQ 5'h11
`define BRF_MODE_IRQ 5'h12
`define BRF_MODE_SVC 5'h13
`define BRF_MODE_ABT 5'h17
`define BRF_MODE_UND 5'h1b
`define BRF_MODE_SYS 5'h1f
// special register numbers
`define BRF_REG_LOW_LAST 4'h7
`define BRF_REG_FIQ_FIRST 4'h8
`define BRF_REG_SP 4'hd
`define BRF_REG_LINK 4'he
`define BRF_REG_IP 4'hf
// status word fields
`define BRF_SW_MODE_HI 4
`define BRF_SW_STATE_BIT 5
`define BRF_SW_RESET 32'h0000_00d3
// instruction pointer masks per state
`define BRF_IP_MASK_WIDE 32'hffff_fffc
`define BRF_IP_MASK_COMPACT 32'hffff_fffe
`define BRF_IP_RESET 32'h0000_0000
`define BRF_ZERO_WORD 32'h0000_0000
`endif

//--- hdl/brf_pkg.sv
`default_nettype none
package brf_pkg;
  // bank selected by the mode field
  typedef enum logic [2:0] {
    BRF_BANK_USR,
    BRF_BANK_FIQ,
    BRF_BANK_IRQ,
    BRF_BANK_SVC,
    BRF_BANK_ABT,
    BRF_BANK_UND
  } brf_bank_t;
  // one write port request
  typedef struct packed {
    logic en;
    logic [3:0] idx;
    logic [31:0] data;
  } brf_wr_t;
endpackage
`default_nettype wire

//--- tb/brf_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// writeback stage of the core: packs one write request per cycle
module brf_core_model
  import brf_pkg::*;
(
  input wire logic en_i,
  input wire logic [3:0] idx_i,
  input wire logic [31:0] data_i,
  output brf_wr_t wr_o
);
  // no hold-off: the file takes a write every cycle
  assign wr_o = '{en: en_i, idx: idx_i, data: data_i};
endmodule
`default_nettype wire

//--- tb/brf_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module brf_checker
  import brf_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [4:0] mode_i,
  input wire logic compact_i,
  input wire logic [3:0] rd_a_idx_i,
  input wire logic [3:0] rd_b_idx_i,
  input wire logic rd_high_form_i,
  input wire logic csw_wr_i,
  input wire logic [31:0] csw_data_i,
  input wire logic ssw_wr_i,
  input wire logic [31:0] ssw_data_i,
  input wire logic exc_entry_i,
  input wire logic [31:0] rd_a_data_o,
  input wire logic rd_a_denied_o,
  input wire logic [31:0] rd_b_data_o,
  input wire logic rd_b_denied_o,
  input wire logic [31:0] instruction_pointer_o,
  input wire logic [31:0] current_status_word_o,
  input wire logic [31:0] saved_status_word_o,
  input wire logic saved_valid_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // plain high register read in compact state
  logic hi_a;
  assign hi_a = compact_i && !rd_high_form_i && rd_a_idx_i >= 4'h8 && rd_a_idx_i <= 4'hc;
  logic hi_b;
  assign hi_b = compact_i && !rd_high_form_i && rd_b_idx_i >= 4'h8 && rd_b_idx_i <= 4'hc;
  chk_deny_high_b: assert property (hi_b |=> rd_b_denied_o && rd_b_data_o == 32'h0)
    else $error("high read b not refused");
  chk_wide_open_b: assert property (!compact_i |=> !rd_b_denied_o)
    else $error("wide read b refused");
  chk_saved_write: assert property (ssw_wr_i && saved_valid_o && !exc_entry_i ##1 $stable(mode_i)
    |-> saved_status_word_o == $past(ssw_data_i)) else $error("saved word not written");
  chk_ip_wide: assert property (!compact_i |-> instruction_pointer_o[1:0] == 2'h0)
    else $error("wide pointer low bits set");
  chk_ip_compact: assert property (compact_i |-> !instruction_pointer_o[0])
    else $error("compact pointer bit0 set");
  chk_saved_valid: assert property (saved_valid_o == (mode_i inside {`BRF_MODE_FIQ, `BRF_MODE_IRQ,
    `BRF_MODE_SVC, `BRF_MODE_ABT, `BRF_MODE_UND})) else $error("saved valid wrong");
  chk_saved_user: assert property (!saved_valid_o |-> saved_status_word_o == 32'h0)
    else $error("saved word in user");
  chk_deny_high: assert property (hi_a |=> rd_a_denied_o && rd_a_data_o == 32'h0)
    else $error("high read not refused");
  chk_low_open: assert property (rd_a_idx_i <= 4'h7 |=> !rd_a_denied_o)
    else $error("low read refused");
  chk_wide_open: assert property (!compact_i |=> !rd_a_denied_o)
    else $error("wide read refused");
  chk_status_write: assert property (csw_wr_i |=> current_status_word_o == $past(csw_data_i))
    else $error("status word not written");
  cover property (hi_a);
  cover property (saved_valid_o && compact_i);
  cover property (csw_wr_i);
  cover property (ssw_wr_i && saved_valid_o);
endmodule
bind brf_banked_register_file brf_checker u_chk (.clock_i(clock_i), .rst_i(rst_i), .mode_i(mode_i),
  .compact_i(compact_i), .rd_a_idx_i(rd_a_idx_i), .rd_b_idx_i(rd_b_idx_i), .rd_high_form_i(rd_high_form_i),
  .csw_wr_i(csw_wr_i), .csw_data_i(csw_data_i), .ssw_wr_i(ssw_wr_i), .ssw_data_i(ssw_data_i),
  .exc_entry_i(exc_entry_i), .rd_a_data_o(rd_a_data_o), .rd_a_denied_o(rd_a_denied_o),
  .rd_b_data_o(rd_b_data_o), .rd_b_denied_o(rd_b_denied_o),
  .instruction_pointer_o(instruction_pointer_o), .current_status_word_o(current_status_word_o),
  .saved_status_word_o(saved_status_word_o), .saved_valid_o(saved_valid_o));
`default_nettype wire

//--- tb/test_banked_register_file.sv
`timescale 1ns/1ps
`default_nettype none
`include "brf_cfg.svh"
module test_banked_register_file;
  import brf_pkg::*;
  localparam logic [4:0] US = `BRF_MODE_USR, FQ = `BRF_MODE_FIQ, IQ = `BRF_MODE_IRQ;
  localparam logic [4:0] SV = `BRF_MODE_SVC, AB = `BRF_MODE_ABT, SY = `BRF_MODE_SYS;
  localparam logic [4:0] UN = `BRF_MODE_UND;
  logic clk = 0, rst = 1, cp = 0, hf = 0, we = 0, bl = 0, ee = 0, il = 0, cw = 0, na;
  logic sw = 0, nb, sval;
  logic [4:0] md = US, em = AB;
  logic [3:0] ia = '0, wi = '0, rb = 4'h9;
  logic [31:0] wd = '0, lv = 32'hc04, er = 32'he08, da, ip, cs;
  logic [31:0] sd = '0, db, ss;
  brf_wr_t wr;
  int n_fail = 0, compares = 0;
  always #2.5 clk = ~clk;
  brf_core_model core (.en_i(we), .idx_i(wi), .data_i(wd), .wr_o(wr));
  brf_banked_register_file DUT (.clock_i(clk), .rst_i(rst), .mode_i(md), .compact_i(cp), .rd_a_idx_i(ia),
    .rd_b_idx_i(rb), .rd_high_form_i(hf), .wr_i(wr), .branch_with_link_i(bl), .link_value_i(lv),
    .exc_entry_i(ee), .exc_mode_i(em), .exc_return_i(er), .ip_load_i(il), .ip_value_i(32'h1237),
    .csw_wr_i(cw), .csw_data_i(32'h11), .ssw_wr_i(sw), .ssw_data_i(sd), .rd_a_data_o(da),
    .rd_b_data_o(db), .rd_a_denied_o(na), .rd_b_denied_o(nb), .instruction_pointer_o(ip),
    .current_status_word_o(cs), .saved_status_word_o(ss), .saved_valid_o(sval));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write request, then an idle edge so back-to-back calls never re-raise the enable in one step
  task put(input logic [4:0] m, input logic [3:0] i, input logic [31:0] d);
    md = m;
    wi = i;
    wd = d;
    we = 1'b1;
    @(posedge clk) #1;
    we = 1'b0;
    @(posedge clk) #1;
  endtask
  // read data lands one edge after the index
  task get(input logic [4:0] m, input logic [3:0] i, input logic [31:0] e);
    md = m;
    ia = i;
    @(posedge clk) #1;
    chk(da, e);
  endtask
  task t_bank;
    put(US, 4'hd, 32'ha1);
    put(US, 4'h8, 32'hb2);
    put(US, 4'h9, 32'h9d);
    put(FQ, 4'h8, 32'hc3);
    put(IQ, 4'hd, 32'he5);
    get(SY, 4'hd, 32'ha1);
    get(FQ, 4'h8, 32'hc3);
    get(IQ, 4'h8, 32'hb2);
    get(IQ, 4'hd, 32'he5);
    get(US, 4'h8, 32'hb2);
    chk(db, 32'h9d);
    chk({31'h0, nb}, 32'h0);
  endtask
  // saved status: capture on entry, software write, none in system mode
  task t_saved;
    md = AB;
    em = FQ;
    ee = 1'b1;
    @(posedge clk) #1;
    ee = 1'b0;
    chk({31'h0, sval}, 32'h1);
    chk(ss, `BRF_SW_RESET);
    get(FQ, 4'he, er);
    chk(ss, `BRF_SW_RESET);
    md = UN;
    sw = 1'b1;
    sd = 32'h6c;
    @(posedge clk) #1;
    sw = 1'b0;
    chk(ss, 32'h6c);
    @(posedge clk) #1;
    md = SY;
    sw = 1'b1;
    sd = 32'h77;
    @(posedge clk) #1;
    sw = 1'b0;
    chk({31'h0, sval}, 32'h0);
    chk(ss, 32'h0);
    md = UN;
    @(posedge clk) #1;
    chk(ss, 32'h6c);
  endtask
  task t_link;
    md = SV;
    bl = 1'b1;
    @(posedge clk) #1;
    bl = 1'b0;
    ee = 1'b1;
    @(posedge clk) #1;
    ee = 1'b0;
    get(SV, 4'he, lv);
    get(AB, 4'he, er);
    get(US, 4'he, 32'h0);
  endtask
  task t_state;
    put(US, 4'h0, 32'h5a);
    il = 1'b1;
    cw = 1'b1;
    @(posedge clk) #1;
    il = 1'b0;
    cw = 1'b0;
    chk(ip, 32'h1234);
    chk(cs, 32'h11);
    cp = 1'b1;
    get(US, 4'h0, 32'h5a);
    chk(ip, 32'h1236);
    get(US, 4'hd, 32'ha1);
    get(US, 4'hf, 32'h1236);
    get(US, 4'h9, 32'h0);
    chk({31'h0, na}, 32'h1);
    chk(db, 32'h0);
    chk({31'h0, nb}, 32'h1);
    hf = 1'b1;
    get(US, 4'h8, 32'hb2);
    chk(db, 32'h9d);
    chk({31'h0, nb}, 32'h0);
  endtask
  task tally_and_finish;
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk(cs, 32'hd3);
    t_bank;
    t_link;
    t_saved;
    t_state;
    tally_and_finish;
  end
  // run needs about 36 cycles; 400 cycles leave a wide margin
  initial
  begin
    #2000;
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
